// File: rtl/t16w_params.svh
// Register offsets, field positions, reset values and mode constants of the 16-bit waveform timer.
`ifndef T16W_PARAMS_SVH
`define T16W_PARAMS_SVH

`define T16W_OFS_CTRL_A     8'h80
`define T16W_OFS_CTRL_B     8'h84
`define T16W_OFS_CMP_A      8'h88
`define T16W_OFS_CMP_B      8'h8C
`define T16W_OFS_CAPTURE    8'h90
`define T16W_OFS_COUNT      8'h94
`define T16W_OFS_IRQ_STAT   8'h98
`define T16W_OFS_IRQ_MASK   8'h9C
`define T16W_OFS_PIN_DIR    8'hA0

`define T16W_CTRL_A_RESET   8'h00
`define T16W_CTRL_A_WMASK   8'hF3
`define T16W_CTRL_B_WMASK   8'h18
`define T16W_COM_A_HI       7
`define T16W_COM_A_LO       6
`define T16W_COM_B_HI       5
`define T16W_COM_B_LO       4
`define T16W_WGM_HI_HI      4
`define T16W_WGM_HI_LO      3

`define T16W_TOP_8BIT       16'h00FF
`define T16W_TOP_9BIT       16'h01FF
`define T16W_TOP_10BIT      16'h03FF
`define T16W_MAX            16'hFFFF
`define T16W_BOTTOM         16'h0000

`define T16W_IRQ_OVF        0
`define T16W_IRQ_CMPA       1
`define T16W_IRQ_CMPB       2

`endif

// File: rtl/t16w_pkg.sv
// Types shared by the 16-bit waveform timer modules.
package t16w_pkg;

  typedef enum logic [1:0]
  {
    T16W_KIND_NORMAL,
    T16W_KIND_FAST,
    T16W_KIND_DUAL,
    T16W_KIND_OFF
  } t16w_kind_t;

  typedef enum logic [1:0]
  {
    T16W_SRC_FIXED,
    T16W_SRC_CMPA,
    T16W_SRC_CAPTURE
  } t16w_topsrc_t;

  typedef struct packed
  {
    logic        match;
    logic        at_bottom;
    logic        counting_up;
    logic [15:0] compare;
    logic [15:0] top;
  } t16w_chan_evt_t;

endpackage

// File: rtl/t16w_out_unit.sv
// One compare output channel: waveform register and pin override.
`include "t16w_params.svh"

module t16w_out_unit
  import t16w_pkg::*;
#(
  parameter bit CHAN_A = 1'b1
)
(
  input  wire logic           clk_sys,
  input  wire logic           rst_b,
  input  wire logic [1:0]     cmp_out_mode,
  input  wire logic [3:0]     wave_mode,
  input  t16w_kind_t          kind,
  input  t16w_chan_evt_t      evt,
  input  wire logic           pin_dir_out,
  output logic                wave_out,
  output logic                wave_out_oe,
  output logic                pin_override
);

  logic wave_r;
  logic wave_nxt;
  logic toggle_ok;

  // Toggle in PWM kinds exists only for channel A, in fast modes 14 and 15 and dual-slope modes 9 and 11.
  always_comb
  begin
    toggle_ok = 1'b0;
    if (kind == T16W_KIND_FAST)
      toggle_ok = CHAN_A && (wave_mode == 4'd14 || wave_mode == 4'd15); // [R4]
    else if (kind == T16W_KIND_DUAL)
      toggle_ok = CHAN_A && (wave_mode == 4'd9 || wave_mode == 4'd11); // [R7]
    else if (kind == T16W_KIND_NORMAL)
      toggle_ok = 1'b1;
  end

  always_comb
  begin
    wave_nxt = wave_r;
    unique case (kind)
      T16W_KIND_NORMAL:
      begin
        if (evt.match)
        begin
          unique case (cmp_out_mode) // [R3]
            2'b00: wave_nxt = wave_r;
            2'b01: wave_nxt = ~wave_r;
            2'b10: wave_nxt = 1'b0;
            2'b11: wave_nxt = 1'b1;
          endcase
        end
      end
      T16W_KIND_FAST:
      begin
        if (cmp_out_mode[1])
        begin
          // A match at TOP is dropped so the BOTTOM action alone sets the level.
          if (evt.at_bottom)
            wave_nxt = ~cmp_out_mode[0]; // [R5] [R6]
          else if (evt.match && evt.compare != evt.top)
            wave_nxt = cmp_out_mode[0]; // [R5] [R6]
        end
        else if (cmp_out_mode[0] && toggle_ok && evt.match)
          wave_nxt = ~wave_r; // [R4]
      end
      T16W_KIND_DUAL:
      begin
        if (cmp_out_mode[1])
        begin
          // Compare at BOTTOM holds low and at TOP holds high for non-inverting.
          if (evt.compare == `T16W_BOTTOM)
            wave_nxt = cmp_out_mode[0]; // [R15]
          else if (evt.compare == evt.top)
            wave_nxt = ~cmp_out_mode[0]; // [R15]
          else if (evt.match)
            wave_nxt = evt.counting_up ? cmp_out_mode[0] : ~cmp_out_mode[0]; // [R8]
        end
        else if (cmp_out_mode[0] && toggle_ok && evt.match)
          wave_nxt = ~wave_r; // [R7]
      end
      T16W_KIND_OFF:
        wave_nxt = 1'b0; // [R16]
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      wave_r <= 1'b0;
    else
      wave_r <= wave_nxt;
  end

  always_comb
  begin
    pin_override = (cmp_out_mode != 2'b00); // [R1]
    if (kind == T16W_KIND_OFF)
      pin_override = 1'b0; // [R16]
    else if (cmp_out_mode == 2'b01 && kind != T16W_KIND_NORMAL && !toggle_ok)
      pin_override = 1'b0; // [R4] [R7]
  end

  assign wave_out    = wave_r;
  assign wave_out_oe = pin_override && pin_dir_out; // [R2]

endmodule

// File: rtl/t16w_timer.sv
// Top of the 16-bit waveform timer: AXI4-Lite registers, counter and mode decode.
//
// Notes on behaviour
// (R1) Nonzero compare output field hands the pin to that channel's waveform.
// (R2) Pin is driven only when its direction bit selects output.
// (R3) Normal and clear-on-match: 00 off, 01 toggle, 10 low, 11 high on match.
// (R4) Fast PWM field 01 toggles channel A only in modes 14 and 15.
// (R5) Fast PWM 10 clears on match, sets at BOTTOM; 11 is inverted.
// (R6) Fast PWM: match at TOP ignored when upper field bit set; BOTTOM action stays.
// (R7) Dual-slope field 01 toggles channel A only in modes 9 and 11.
// (R8) Dual-slope 10 clears on up-match, sets on down-match; 11 reversed.
// (R9) Mode is low two bits here plus two high bits in second control.
// (R10) Modes 1-3 phase correct, fixed TOP, reload at TOP, overflow at BOTTOM.
// (R11) Mode 0 to 0xFFFF, modes 4 and 12 clear-on-match, immediate, overflow at MAX.
// (R12) Fast PWM modes reload compares at BOTTOM and flag overflow at TOP.
// (R13) Modes 8,9 reload at BOTTOM; 10,11 at TOP; all overflow at BOTTOM.
// (R14) Dual-slope counts zero up to TOP, then back down to zero.
// (R15) Phase correct compare at BOTTOM holds low, at TOP holds high.
// (R16) Reserved mode 13 stops the counter and disconnects both outputs.
// (R17) Bits 3 and 2 of the first control register ignore writes, read zero.
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "t16w_params.svh"

module t16w_timer
  import t16w_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             wave_out_a,
  output logic             wave_out_a_oe,
  output logic             wave_out_a_override,
  output logic             wave_out_b,
  output logic             wave_out_b_oe,
  output logic             wave_out_b_override,
  output logic             irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]  ctrl_a_r;
  logic [1:0]  wave_mode_high_r;
  logic [15:0] cmp_a_buf_r;
  logic [15:0] cmp_b_buf_r;
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [15:0] capture_value_r;
  logic [15:0] count_value_r;
  logic        count_up_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [1:0]  pin_dir_r;

  logic        aw_hold_r;
  logic [7:0]  aw_addr_r;
  logic        w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  logic [3:0]     wave_mode;
  t16w_kind_t     kind;
  t16w_topsrc_t   top_src;
  logic [15:0]    top_val;
  logic           reload_at_top;
  logic           ovf_at_bottom;
  logic           immediate;
  logic           at_top;
  logic           at_bottom;
  logic           match_a;
  logic           match_b;
  logic           ovf_evt;
  logic           wr_do;
  logic           rd_do;
  logic           wr_cnt;
  logic           rd_stat;
  t16w_chan_evt_t evt_a;
  t16w_chan_evt_t evt_b;

  assign wave_mode = {wave_mode_high_r, ctrl_a_r[1:0]}; // [R9]

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  always_comb
  begin
    kind          = T16W_KIND_NORMAL;
    top_src       = T16W_SRC_FIXED;
    top_val       = `T16W_MAX;
    reload_at_top = 1'b0;
    ovf_at_bottom = 1'b0;
    immediate     = 1'b1;
    unique case (wave_mode)
      4'd0: top_val = `T16W_MAX; // [R11]
      4'd1, 4'd2, 4'd3:
      begin
        kind          = T16W_KIND_DUAL; // [R10]
        reload_at_top = 1'b1;
        ovf_at_bottom = 1'b1;
        immediate     = 1'b0;
      end
      4'd4: top_src = T16W_SRC_CMPA; // [R11]
      4'd12: top_src = T16W_SRC_CAPTURE; // [R11]
      4'd5, 4'd6, 4'd7:
      begin
        kind      = T16W_KIND_FAST; // [R12]
        immediate = 1'b0;
      end
      4'd14, 4'd15:
      begin
        kind      = T16W_KIND_FAST; // [R12]
        top_src   = wave_mode[0] ? T16W_SRC_CMPA : T16W_SRC_CAPTURE;
        immediate = 1'b0;
      end
      4'd8, 4'd9, 4'd10, 4'd11:
      begin
        kind          = T16W_KIND_DUAL; // [R13]
        top_src       = wave_mode[0] ? T16W_SRC_CMPA : T16W_SRC_CAPTURE;
        reload_at_top = wave_mode[1];
        ovf_at_bottom = 1'b1;
        immediate     = 1'b0;
      end
      4'd13: kind = T16W_KIND_OFF; // [R16]
    endcase
    if (top_src == T16W_SRC_FIXED && wave_mode != 4'd0)
    begin
      unique case (wave_mode[1:0]) // [R10] [R12]
        2'd1: top_val = `T16W_TOP_8BIT;
        2'd2: top_val = `T16W_TOP_9BIT;
        default: top_val = `T16W_TOP_10BIT;
      endcase
    end
    else if (top_src == T16W_SRC_CMPA)
      top_val = cmp_a_r;
    else if (top_src == T16W_SRC_CAPTURE)
      top_val = capture_value_r;
  end

  assign at_top    = (count_value_r == top_val);
  assign at_bottom = (count_value_r == `T16W_BOTTOM);
  assign match_a   = (count_value_r == cmp_a_r) && kind != T16W_KIND_OFF;
  assign match_b   = (count_value_r == cmp_b_r) && kind != T16W_KIND_OFF;

  // Overflow event follows the mode's flag point.
  always_comb
  begin
    ovf_evt = 1'b0;
    unique case (kind)
      T16W_KIND_NORMAL: ovf_evt = (count_value_r == `T16W_MAX); // [R11]
      T16W_KIND_FAST:   ovf_evt = at_top; // [R12]
      T16W_KIND_DUAL:   ovf_evt = at_bottom && !count_up_r; // [R10] [R13]
      T16W_KIND_OFF:    ovf_evt = 1'b0;
    endcase
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  assign wr_cnt = wr_do && aw_addr_r == `T16W_OFS_COUNT;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_value_r <= 16'h0000;
      count_up_r    <= 1'b1;
    end
    else if (wr_cnt)
      count_value_r <= w_data_r[15:0];
    else
    begin
      unique case (kind)
        T16W_KIND_DUAL:
        begin
          // Direction flips on the terminal value, giving one cycle at TOP.
          if (count_up_r && count_value_r >= top_val)
          begin
            count_up_r    <= 1'b0; // [R14]
            count_value_r <= count_value_r - 16'h0001;
          end
          else if (!count_up_r && at_bottom)
          begin
            count_up_r    <= 1'b1; // [R14]
            count_value_r <= count_value_r + 16'h0001;
          end
          else if (count_up_r)
            count_value_r <= count_value_r + 16'h0001;
          else
            count_value_r <= count_value_r - 16'h0001;
        end
        T16W_KIND_OFF:
          count_value_r <= count_value_r;
        default:
        begin
          count_up_r    <= 1'b1;
          count_value_r <= at_top ? 16'h0000 : count_value_r + 16'h0001;
        end
      endcase
    end
  end

  // ****************************************************************
  // Compare double buffering
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmp_a_r <= 16'h0000;
      cmp_b_r <= 16'h0000;
    end
    else if (immediate || (reload_at_top ? at_top : at_bottom)) // [R11] [R12] [R13]
    begin
      cmp_a_r <= cmp_a_buf_r;
      cmp_b_r <= cmp_b_buf_r;
    end
  end

  assign evt_a = '{match: match_a, at_bottom: at_bottom, counting_up: count_up_r,
                   compare: cmp_a_r, top: top_val};
  assign evt_b = '{match: match_b, at_bottom: at_bottom, counting_up: count_up_r,
                   compare: cmp_b_r, top: top_val};

  t16w_out_unit #(.CHAN_A(1'b1)) u_out_a
  (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .cmp_out_mode (ctrl_a_r[`T16W_COM_A_HI:`T16W_COM_A_LO]),
    .wave_mode    (wave_mode),
    .kind         (kind),
    .evt          (evt_a),
    .pin_dir_out  (pin_dir_r[0]),
    .wave_out     (wave_out_a),
    .wave_out_oe  (wave_out_a_oe),
    .pin_override (wave_out_a_override)
  );

  t16w_out_unit #(.CHAN_A(1'b0)) u_out_b
  (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .cmp_out_mode (ctrl_a_r[`T16W_COM_B_HI:`T16W_COM_B_LO]),
    .wave_mode    (wave_mode),
    .kind         (kind),
    .evt          (evt_b),
    .pin_dir_out  (pin_dir_r[1]),
    .wave_out     (wave_out_b),
    .wave_out_oe  (wave_out_b_oe),
    .pin_override (wave_out_b_override)
  );

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_do         = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_do         = s_axi_arvalid && !rvalid_r;
  assign rd_stat       = rd_do && s_axi_araddr == `T16W_OFS_IRQ_STAT;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (aw_addr_r > `T16W_OFS_PIN_DIR || aw_addr_r < `T16W_OFS_CTRL_A ||
                      aw_addr_r[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Registers are at most 16 bits wide, so only the two low byte lanes matter.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_a_r         <= `T16W_CTRL_A_RESET;
      wave_mode_high_r <= 2'b00;
      cmp_a_buf_r      <= 16'h0000;
      cmp_b_buf_r      <= 16'h0000;
      capture_value_r  <= 16'h0000;
      irq_mask_r       <= 3'b000;
      pin_dir_r        <= 2'b00;
    end
    else if (wr_do && w_strb_r[0])
    begin
      unique case (aw_addr_r)
        `T16W_OFS_CTRL_A:   ctrl_a_r <= w_data_r[7:0] & `T16W_CTRL_A_WMASK; // [R17]
        `T16W_OFS_CTRL_B:   wave_mode_high_r <= w_data_r[`T16W_WGM_HI_HI:`T16W_WGM_HI_LO];
        `T16W_OFS_CMP_A:    cmp_a_buf_r <= {w_strb_r[1] ? w_data_r[15:8] : cmp_a_buf_r[15:8],
                                            w_data_r[7:0]};
        `T16W_OFS_CMP_B:    cmp_b_buf_r <= {w_strb_r[1] ? w_data_r[15:8] : cmp_b_buf_r[15:8],
                                            w_data_r[7:0]};
        `T16W_OFS_CAPTURE:  capture_value_r <= {w_strb_r[1] ? w_data_r[15:8] :
                                                capture_value_r[15:8], w_data_r[7:0]};
        `T16W_OFS_IRQ_MASK: irq_mask_r <= w_data_r[2:0];
        `T16W_OFS_PIN_DIR:  pin_dir_r <= w_data_r[1:0];
        default:            pin_dir_r <= pin_dir_r;
      endcase
    end
  end

  // A new event wins over the clear caused by reading the status.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_stat_r <= 3'b000;
    else
      irq_stat_r <= (rd_stat ? 3'b000 : irq_stat_r) | {match_b, match_a, ovf_evt};
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'b00;
    end
    else if (rd_do)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= 2'b00;
      unique case (s_axi_araddr)
        `T16W_OFS_CTRL_A:   rdata_r <= {24'h00_0000, ctrl_a_r}; // [R17]
        `T16W_OFS_CTRL_B:   rdata_r <= {27'h000_0000, wave_mode_high_r, 3'b000};
        `T16W_OFS_CMP_A:    rdata_r <= {16'h0000, cmp_a_buf_r};
        `T16W_OFS_CMP_B:    rdata_r <= {16'h0000, cmp_b_buf_r};
        `T16W_OFS_CAPTURE:  rdata_r <= {16'h0000, capture_value_r};
        `T16W_OFS_COUNT:    rdata_r <= {16'h0000, count_value_r};
        `T16W_OFS_IRQ_STAT: rdata_r <= {29'h0000_0000, irq_stat_r};
        `T16W_OFS_IRQ_MASK: rdata_r <= {29'h0000_0000, irq_mask_r};
        `T16W_OFS_PIN_DIR:  rdata_r <= {30'h0000_0000, pin_dir_r};
        default:
        begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= 2'b10;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule

// File: tb/t16w_timer_props.sv
// Concurrent checks on the bus and pin outputs of the 16-bit waveform timer.
`include "t16w_params.svh"

module t16w_timer_chk
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        wave_out_a_oe,
  input wire logic        wave_out_a_override,
  input wire logic        wave_out_b_oe,
  input wire logic        wave_out_b_override
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_stall;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  property p_oe_a;
    wave_out_a_oe |-> wave_out_a_override;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin A driven without override");
  property p_oe_b;
    wave_out_b_oe |-> wave_out_b_override;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin B driven without override");
  property p_r_answer;
    s_ar_taken |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_hold;
    s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped before taken");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("address taken while read pending");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rsvd_zero;
    s_ar_taken ##0 (s_axi_araddr == `T16W_OFS_CTRL_A) |=> s_axi_rdata[3:2] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");
  property p_unmapped;
    s_ar_taken ##0 (s_axi_araddr == 8'h04) |=>
      s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule

bind t16w_timer t16w_timer_chk u_chk
(
  .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .wave_out_a_oe(wave_out_a_oe),
  .wave_out_a_override(wave_out_a_override), .wave_out_b_oe(wave_out_b_oe),
  .wave_out_b_override(wave_out_b_override)
);

// File: tb/t16w_timer_tb.sv
// Self-checking bench for the 16-bit waveform timer.
`include "t16w_params.svh"

module t16w_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [33:0] ALL   = 34'h3_FFFF_FFFF;
  localparam logic [15:0] TOG_A = 16'hDA11;
  localparam logic [15:0] TOG_B = 16'h1011;
  logic        clk_sys = 1'b0, rst_b = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic        awrdy, wrdy, bv, arrdy, rv, oa, ob, oea, oeb, ova, ovb, irq;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  logic [33:0] exp_q[$], msk_q[$], m, e;
  int          err_count = 0, total_checks = 0, cyc = 0;

  t16w_timer DUT
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rr), .wave_out_a(oa),
    .wave_out_a_oe(oea), .wave_out_a_override(ova), .wave_out_b(ob), .wave_out_b_oe(oeb),
    .wave_out_b_override(ovb), .irq(irq)
  );

  always #20 clk_sys = ~clk_sys;

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    total_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // Read data are stable at the falling edge before the handshake edge.
  always @(negedge clk_sys)
    if (rst_b && rv && rre && exp_q.size() > 0)
    begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      check({rr, rdat} & m, e & m);
    end

  always @(negedge clk_sys)
    if (rst_b && bv && bre)
      check(34'(br), 34'h0_0000_0000);

  // ****************************************************************
  // Bus and waveform tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, tv;
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'($urandom);
    do
    begin
      @(negedge clk_sys);
      ta = awv && awrdy;
      tw = wv && wrdy;
      tb = bre && bv;
      tv = bv;
      @(posedge clk_sys);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      bre <= !tb && (bre || tv);
    end
    while (!tb);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] want, input logic [33:0] care);
    logic ta, tr, tv;
    @(posedge clk_sys);
    exp_q.push_back(want);
    msk_q.push_back(care);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'($urandom);
    do
    begin
      @(negedge clk_sys);
      ta = arv && arrdy;
      tr = rre && rv;
      tv = rv;
      @(posedge clk_sys);
      if (ta) arv <= 1'b0;
      rre <= !tr && (rre || tv);
    end
    while (!tr);
  endtask

  task automatic set_mode(input logic [3:0] md, input logic [1:0] ca, input logic [1:0] cb);
    wr(`T16W_OFS_CTRL_B, 32'({md[3:2], 3'b000}));
    wr(`T16W_OFS_CTRL_A, 32'({ca, cb, 2'b00, md[1:0]}));
  endtask

  // The settle time covers a full reload cycle of the buffered compares.
  task automatic duty(input int p, output int ha, output int hb);
    repeat (600) @(posedge clk_sys);
    ha = 0;
    hb = 0;
    repeat (p)
    begin
      @(negedge clk_sys);
      ha += int'(oa);
      hb += int'(ob);
    end
  endtask

  task automatic per(output int c);
    logic v;
    @(negedge clk_sys);
    for (int k = 0; k < 2; k++)
    begin
      v = oa;
      c = 0;
      while (oa === v && c < 3000)
      begin
        @(negedge clk_sys);
        c++;
      end
    end
  endtask

  initial
  begin
    int n, k, c, ha, hb, hi, hn;
    logic [1:0] dir;
    void'($urandom(54));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(`T16W_OFS_CTRL_A, 34'h0_0000_0000, ALL);
    rd(`T16W_OFS_CMP_A, 34'h0_0000_0000, ALL);
    wr(`T16W_OFS_CTRL_A, 32'h0000_00FF);
    rd(`T16W_OFS_CTRL_A, 34'h0_0000_00F3, ALL);
    wr(`T16W_OFS_CTRL_B, 32'h0000_00FF);
    rd(`T16W_OFS_CTRL_B, 34'h0_0000_0018, ALL);
    rd(8'h04, 34'h2_0000_0000, ALL);
    $display("test registers done");
    for (k = 0; k < 4; k++)
    begin
      dir = 2'($urandom);
      wr(`T16W_OFS_PIN_DIR, 32'(dir));
      set_mode(4'h4, 2'(k), 2'(3 - k));
      @(negedge clk_sys);
      check(34'({ova, oea, ovb, oeb}),
            34'({k != 0, k != 0 && dir[0], k != 3, k != 3 && dir[1]}));
    end
    $display("test pin takeover done");
    n = 16 + int'($urandom % 32);
    wr(`T16W_OFS_CMP_A, 32'(n));
    set_mode(4'h4, 2'b01, 2'b00);
    // Earlier modes leave the counter above the new TOP, so it would run to MAX first.
    wr(`T16W_OFS_COUNT, 32'h0000_0000);
    per(c);
    check(34'(c), 34'(n + 1));
    wr(`T16W_OFS_CAPTURE, 32'(n + 20));
    set_mode(4'hC, 2'b01, 2'b00);
    per(c);
    check(34'(c), 34'(n + 21));
    for (k = 2; k < 4; k++)
    begin
      set_mode(4'hC, 2'(k), 2'b00);
      repeat (n + 25) @(posedge clk_sys);
      check(34'(oa), 34'(k - 2));
    end
    $display("test clear on match done");
    wr(`T16W_OFS_PIN_DIR, 32'h0000_0003);
    for (k = 0; k < 16; k++)
    begin
      set_mode(4'(k), 2'b01, 2'b01);
      @(negedge clk_sys);
      check(34'({ova, ovb}), 34'({TOG_A[k], TOG_B[k]}));
    end
    $display("test toggle field done");
    for (k = 0; k < 3; k++)
    begin
      c = (k == 0) ? 0 : (k == 1) ? 1 + int'($urandom % 254) : 255;
      wr(`T16W_OFS_CMP_A, 32'(c));
      wr(`T16W_OFS_CMP_B, 32'(255 - c));
      set_mode(4'h1, 2'b10, 2'b11);
      duty(510, ha, hb);
      check(34'(ha), 34'(2 * c));
      check(34'(hb), 34'(2 * c));
    end
    $display("test dual slope done");
    c = 1 + int'($urandom % 254);
    wr(`T16W_OFS_CMP_A, 32'(c));
    wr(`T16W_OFS_CMP_B, 32'h0000_00FF);
    set_mode(4'h5, 2'b10, 2'b10);
    duty(256, hn, hb);
    check(34'(hb), 34'(256));
    set_mode(4'h5, 2'b11, 2'b11);
    duty(256, hi, hb);
    check(34'(hb), 34'(0));
    check(34'(hn + hi), 34'(256));
    check(34'(hn), 34'(c));
    $display("test fast pwm done");
    wr(`T16W_OFS_IRQ_MASK, 32'h0000_0000);
    repeat (300) @(posedge clk_sys);
    check(34'(irq), 34'h0_0000_0000);
    rd(`T16W_OFS_IRQ_STAT, 34'h0_0000_0007, 34'h0_0000_0007);
    wr(`T16W_OFS_IRQ_MASK, 32'h0000_0001);
    repeat (300) @(posedge clk_sys);
    check(34'(irq), 34'h0_0000_0001);
    set_mode(4'hD, 2'b10, 2'b10);
    rd(`T16W_OFS_IRQ_STAT, 34'h0_0000_0007, 34'h0_0000_0007);
    rd(`T16W_OFS_IRQ_STAT, 34'h0_0000_0000, ALL);
    @(negedge clk_sys);
    check(34'({irq, ova, ovb, oea, oeb}), 34'h0_0000_0000);
    $display("test interrupts done");
    print_verdict();
  end
endmodule
